/* design/afe_interrupt_flags_custom_gen.sv */
// Purpose: Lower interrupt status flags and custom interrupt generator
// Assumes: All event, sequencer and host ports come from clk_i logic
// Notes:   Limit registers and clear logic sit outside this block
//
// How it works
// - Bits 9-12 show custom interrupts 0-3
// - Bits 0-3, 7, 8 flag result events
// - Bit 6 sticks on large step between results
// - Bit 5 sets on result above upper limit
// - Bit 4 sticks on result below lower limit
// - Host writes never change the generator register
// - Sequencer writing one triggers that custom interrupt
// - Generator resets 0x10, upper field read-only
// - Two flag banks, reset zero, host read-only
`timescale 1ns/10ps
`include "afe_irq_params.svh"

module afe_interrupt_flags_custom_gen #(
	parameter int ADC_W = 16
) (
	input  wire logic                       clk_i,
	input  wire logic                       rst_n_i,
	input  wire logic                       adc_result_ready_i,
	input  wire logic                       dft_result_i,
	input  wire logic                       sinc2_ready_i,
	input  wire logic                       temperature_result_i,
	input  wire logic                       mean_event_i,
	input  wire logic                       variance_event_i,
	input  wire logic                       adc_valid_i,
	input  wire logic [ADC_W-1:0]           adc_data_i,
	input  wire logic [ADC_W-1:0]           adc_lower_limit_i,
	input  wire logic [ADC_W-1:0]           adc_upper_limit_i,
	input  wire logic [ADC_W-1:0]           adc_step_limit_i,
	input  wire logic                       seq_wr_i,
	input  wire logic [`IRQF_ADDR_W-1:0]    seq_addr_i,
	input  wire logic [`IRQF_DATA_W-1:0]    seq_wdata_i,
	input  wire logic                       host_wr_i,
	input  wire logic                       host_rd_i,
	input  wire logic [`IRQF_ADDR_W-1:0]    host_addr_i,
	input  wire afe_irq_pkg::flag_vec_t     bank0_clear_i,
	input  wire afe_irq_pkg::flag_vec_t     bank1_clear_i,
	output wire afe_irq_pkg::flag_vec_t     irq_status_bank_0_o,
	output wire afe_irq_pkg::flag_vec_t     irq_status_bank_1_o,
	output wire logic [`IRQF_DATA_W-1:0]    host_rdata_o,
	output wire logic                       host_rvalid_o
);

	localparam int NUM_BANKS = 2;

	if (ADC_W < 2 || ADC_W > 31) begin : g_bad_width
		$error("ADC_W must lie between 2 and 31");
	end

	typedef struct packed {
		logic [`IRQF_NUM_CUSTOM-1:0] gen;
		logic [ADC_W-1:0]            prev;
		logic                        prev_ok;
		logic [`IRQF_DATA_W-1:0]     rdata;
		logic                        rvalid;
	} main_state_s;

	localparam main_state_s ST_RST = '{
		gen:     '0,
		prev:    '0,
		prev_ok: 1'b0,
		rdata:   '0,
		rvalid:  1'b0
	};

	main_state_s             st_r;
	main_state_s             st_nxt;
	afe_irq_pkg::flag_vec_t  ev;
	afe_irq_pkg::flag_vec_t  clr_arr   [NUM_BANKS];
	afe_irq_pkg::flag_vec_t  flags_arr [NUM_BANKS];
	logic                    gen_wr;
	logic [ADC_W-1:0]        step;

	// Host reads of the generator return the reset pattern plus live bits;
	// the host is not meant to trust them anyway
	function automatic logic [`IRQF_DATA_W-1:0] read_mux(
		input logic [`IRQF_ADDR_W-1:0]     addr,
		input afe_irq_pkg::flag_vec_t      f0,
		input afe_irq_pkg::flag_vec_t      f1,
		input logic [`IRQF_NUM_CUSTOM-1:0] gen
	);
		logic [`IRQF_DATA_W-1:0] res;
		res = '0;
		unique case (addr)
			`IRQF_BANK0_OFS: res = {19'h0, f0};
			`IRQF_BANK1_OFS: res = {19'h0, f1};
			`IRQF_GEN_OFS:   res = `IRQF_GEN_RST | {28'h0, gen};
			default:         res = '0;
		endcase
		return res;
	endfunction

	// Only the sequencer port can reach the generator
	assign gen_wr = seq_wr_i && (seq_addr_i == `IRQF_GEN_OFS);

	assign step = (adc_data_i >= st_r.prev) ? adc_data_i - st_r.prev
	                                        : st_r.prev - adc_data_i;

	always_comb begin
		ev = '0;
		ev[`IRQF_BIT_ADC_RDY] = adc_result_ready_i;
		ev[`IRQF_BIT_DFT]     = dft_result_i;
		ev[`IRQF_BIT_SINC2]   = sinc2_ready_i;
		ev[`IRQF_BIT_TEMP]    = temperature_result_i;
		ev[`IRQF_BIT_MEAN]    = mean_event_i;
		ev[`IRQF_BIT_VAR]     = variance_event_i;
		ev[`IRQF_BIT_MIN]     = adc_valid_i
		                        && (adc_data_i < adc_lower_limit_i);
		ev[`IRQF_BIT_MAX]     = adc_valid_i
		                        && (adc_data_i > adc_upper_limit_i);
		// The first result after reset has no neighbour to compare with
		ev[`IRQF_BIT_DELTA]   = adc_valid_i && st_r.prev_ok
		                        && (step > adc_step_limit_i);
		// Writing zero leaves a custom flag alone
		ev[`IRQF_BIT_CUSTOM3:`IRQF_BIT_CUSTOM0] =
			gen_wr ? seq_wdata_i[`IRQF_NUM_CUSTOM-1:0] : '0;
	end

	always_comb begin
		st_nxt = st_r;
		// Trigger bits live for one cycle; host writes are ignored
		st_nxt.gen = gen_wr ? seq_wdata_i[`IRQF_NUM_CUSTOM-1:0]
		                    : '0;
		if (adc_valid_i) begin
			st_nxt.prev    = adc_data_i;
			st_nxt.prev_ok = 1'b1;
		end
		st_nxt.rvalid = host_rd_i;
		if (host_rd_i) begin
			st_nxt.rdata = read_mux(host_addr_i, flags_arr[0],
			                        flags_arr[1], st_r.gen);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r <= ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign clr_arr[0] = bank0_clear_i;
	assign clr_arr[1] = bank1_clear_i;

	for (genvar g = 0; g < NUM_BANKS; g++) begin : g_bank
		flag_bank_if fb ();
		assign fb.set       = ev;
		assign fb.clr       = clr_arr[g];
		assign flags_arr[g] = fb.flags;
		irq_flag_bank irq_flag_bank_inst (
			.clk_i   (clk_i),
			.rst_n_i (rst_n_i),
			.bus     (fb.bank)
		);
	end

	assign irq_status_bank_0_o = flags_arr[0];
	assign irq_status_bank_1_o = flags_arr[1];
	assign host_rdata_o        = st_r.rdata;
	assign host_rvalid_o       = st_r.rvalid;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_CUSTOM_TRIGGER: assert property (
		gen_wr && seq_wdata_i[2]
		|=> irq_status_bank_0_o[11] && irq_status_bank_1_o[11])
		else $error("custom interrupt 2 not raised");

	AST_CUSTOM_TIMING: assert property (
		!irq_status_bank_0_o[9] && gen_wr && seq_wdata_i[0]
		|=> $rose(irq_status_bank_0_o[9]))
		else $error("custom flag 0 not set one cycle after write");

	AST_CUSTOM_ONLY_SEQ: assert property (
		$rose(irq_status_bank_1_o[12])
		|-> $past(gen_wr) && $past(seq_wdata_i[3]))
		else $error("custom flag 3 rose without sequencer write");

	AST_HOST_WRITE_IGNORED: assert property (
		host_wr_i && !gen_wr |=> st_r.gen == 4'h0)
		else $error("host write altered generator");

	AST_GEN_READBACK: assert property (
		host_rd_i && host_addr_i == `IRQF_GEN_OFS
		|=> host_rvalid_o && host_rdata_o[31:4] == 28'h1)
		else $error("generator upper field wrong");

	AST_BANK_READ: assert property (
		host_rd_i && host_addr_i == `IRQF_BANK1_OFS
		|=> host_rdata_o == {19'h0, $past(irq_status_bank_1_o)})
		else $error("bank 1 read data wrong");

	AST_RESULT_FLAG: assert property (
		dft_result_i |=> irq_status_bank_0_o[1] && irq_status_bank_1_o[1])
		else $error("result flag not set");

	AST_MIN_FAIL: assert property (
		adc_valid_i && adc_data_i < adc_lower_limit_i
		|=> irq_status_bank_0_o[4])
		else $error("min fail flag not set");

	AST_MAX_FAIL: assert property (
		$rose(irq_status_bank_0_o[5])
		|-> $past(adc_valid_i) && $past(adc_data_i > adc_upper_limit_i))
		else $error("max fail flag rose without cause");

	AST_DELTA_FAIL: assert property (
		adc_valid_i && st_r.prev_ok && step > adc_step_limit_i
		|=> irq_status_bank_1_o[6])
		else $error("delta fail flag not set");

	COV_CUSTOM: cover property (gen_wr ##1 irq_status_bank_0_o[9]);
	COV_DELTA: cover property (adc_valid_i ##[1:4] $rose(
		irq_status_bank_0_o[6]));
	COV_CLEAR: cover property (irq_status_bank_0_o[4] && bank0_clear_i[4]
		##1 !irq_status_bank_0_o[4]);
	COV_GEN_READ: cover property (host_rd_i
		&& host_addr_i == `IRQF_GEN_OFS);

endmodule

/* pkg/afe_irq_params.svh */
// Purpose: Offsets, bit positions and reset values of the flag block
// Assumes: Included by bare name wherever the numbers are needed
// Notes:   Definitions only
`ifndef AFE_IRQ_PARAMS_SVH
`define AFE_IRQ_PARAMS_SVH

`define IRQF_ADDR_W        16
`define IRQF_DATA_W        32
`define IRQF_BANK0_OFS     16'h3010
`define IRQF_BANK1_OFS     16'h3014
`define IRQF_GEN_OFS       16'h209C
`define IRQF_GEN_RST       32'h0000_0010
`define IRQF_BANK_RST      13'h0000
`define IRQF_NUM_FLAGS     13
`define IRQF_NUM_CUSTOM    4
`define IRQF_BIT_ADC_RDY   0
`define IRQF_BIT_DFT       1
`define IRQF_BIT_SINC2     2
`define IRQF_BIT_TEMP      3
`define IRQF_BIT_MIN       4
`define IRQF_BIT_MAX       5
`define IRQF_BIT_DELTA     6
`define IRQF_BIT_MEAN      7
`define IRQF_BIT_VAR       8
`define IRQF_BIT_CUSTOM0   9
`define IRQF_BIT_CUSTOM3   12

`endif

/* pkg/afe_irq_pkg.sv */
// Purpose: Shared types of the interrupt flag block
// Assumes: Nothing is imported; users write afe_irq_pkg::name
// Notes:   Widths come from the params header
`include "afe_irq_params.svh"

package afe_irq_pkg;

	typedef logic [`IRQF_NUM_FLAGS-1:0] flag_vec_t;

	typedef struct packed {
		flag_vec_t flags;
	} bank_state_s;

endpackage

/* pkg/flag_bank_if.sv */
// Purpose: Carries set, clear and flag vectors to one flag bank
// Assumes: One clock shared by both ends
// Notes:   ctl side is the controller, bank side holds the flags
`timescale 1ns/10ps

interface flag_bank_if;
	afe_irq_pkg::flag_vec_t set;
	afe_irq_pkg::flag_vec_t clr;
	afe_irq_pkg::flag_vec_t flags;

	modport bank (input set, input clr, output flags);
	modport ctl  (output set, output clr, input flags);
endinterface

/* design/irq_flag_bank.sv */
// Purpose: One bank of sticky interrupt status flags
// Assumes: Set and clear pulses come from logic on clk_i
// Notes:   Set wins over a clear in the same cycle
`timescale 1ns/10ps
`include "afe_irq_params.svh"

module irq_flag_bank (
	input  wire logic  clk_i,
	input  wire logic  rst_n_i,
	flag_bank_if.bank  bus
);

	afe_irq_pkg::bank_state_s st_r;
	afe_irq_pkg::bank_state_s st_nxt;

	always_comb begin
		st_nxt = st_r;
		// Hold until cleared, and a late event is never lost
		st_nxt.flags = (st_r.flags & ~bus.clr) | bus.set;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r.flags <= `IRQF_BANK_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign bus.flags = st_r.flags;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_BANK_STICKY: assert property (
		st_r.flags[0] && !bus.clr[0] |=> st_r.flags[0])
		else $error("flag dropped without a clear");
	AST_BANK_SET_WINS: assert property (
		bus.set[4] && bus.clr[4] |=> st_r.flags[4])
		else $error("set lost against a clear");
	AST_BANK_CLEAR: assert property (
		bus.clr[9] && !bus.set[9] |=> !st_r.flags[9] [*1])
		else $error("clear did not take");

endmodule

/* testbench/host_seq_model.sv */
// Purpose: Host and sequencer model driving the flag block
// Assumes: Requests launch just after a rising edge of clk_i
// Notes:   Released address and data lines show the inverse of their last value
`timescale 1ns/10ps

module host_seq_model (
	input  wire logic        clk_i,
	input  wire logic        rvalid_i,
	input  wire logic [31:0] rdata_i,
	output logic             seq_wr_o,
	output logic [15:0]      seq_addr_o,
	output logic [31:0]      seq_wdata_o,
	output logic             host_wr_o,
	output logic             host_rd_o,
	output logic [15:0]      host_addr_o
);
	initial begin
		seq_wr_o = 1'h0;
		seq_addr_o = 16'h0000;
		seq_wdata_o = 32'h0000_0000;
		host_wr_o = 1'h0;
		host_rd_o = 1'h0;
		host_addr_o = 16'h0000;
	end

	task automatic seq_write(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk_i);
		seq_wr_o <= 1'h1;
		seq_addr_o <= a;
		seq_wdata_o <= d;
		@(posedge clk_i);
		seq_wr_o <= 1'h0;
		seq_addr_o <= ~a;
		seq_wdata_o <= ~d;
	endtask

	task automatic host_access(input logic wr, input logic [15:0] a,
		output logic v, output logic [31:0] d);
		@(posedge clk_i);
		host_wr_o <= wr;
		host_rd_o <= ~wr;
		host_addr_o <= a;
		@(posedge clk_i);
		host_wr_o <= 1'h0;
		host_rd_o <= 1'h0;
		host_addr_o <= ~a;
		#1;
		// Data handed back raw; callers decide if it means anything
		v = rvalid_i;
		d = rdata_i;
	endtask
endmodule

/* testbench/test_afe_interrupt_flags_custom_gen.sv */
// Purpose: Self-checking bench of the flag block
// Assumes: Flags answer one cycle after their cause
// Notes:   No mid-run reset; size traded for scenario count
`timescale 1ns/10ps

module test_afe_interrupt_flags_custom_gen;
	logic                   clk_i;
	logic                   rst_n_i;
	logic [5:0]             ev;
	logic                   av;
	logic [15:0]            ad;
	logic [15:0]            lo, hi, stp;
	logic                   s_wr, h_wr, h_rd, rv;
	logic [15:0]            s_a, h_a;
	logic [31:0]            s_d, rd;
	afe_irq_pkg::flag_vec_t c0, c1, b0, b1;
	int                     mismatches = 0;
	int                     n_compared = 0;

	afe_interrupt_flags_custom_gen #(.ADC_W(16))
		afe_interrupt_flags_custom_gen_inst (
		.clk_i(clk_i), .rst_n_i(rst_n_i),
		.adc_result_ready_i(ev[0]), .dft_result_i(ev[1]),
		.sinc2_ready_i(ev[2]), .temperature_result_i(ev[3]),
		.mean_event_i(ev[4]), .variance_event_i(ev[5]),
		.adc_valid_i(av), .adc_data_i(ad),
		.adc_lower_limit_i(lo), .adc_upper_limit_i(hi),
		.adc_step_limit_i(stp),
		.seq_wr_i(s_wr), .seq_addr_i(s_a), .seq_wdata_i(s_d),
		.host_wr_i(h_wr), .host_rd_i(h_rd), .host_addr_i(h_a),
		.bank0_clear_i(c0), .bank1_clear_i(c1),
		.irq_status_bank_0_o(b0), .irq_status_bank_1_o(b1),
		.host_rdata_o(rd), .host_rvalid_o(rv));

	host_seq_model host_seq_model_inst (
		.clk_i(clk_i), .rvalid_i(rv), .rdata_i(rd),
		.seq_wr_o(s_wr), .seq_addr_o(s_a), .seq_wdata_o(s_d),
		.host_wr_o(h_wr), .host_rd_o(h_rd), .host_addr_o(h_a));

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic banks(input logic [12:0] e0, input logic [12:0] e1);
		chk({19'h0, b0}, {19'h0, e0});
		chk({19'h0, b1}, {19'h0, e1});
	endtask

	task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
		logic        v;
		logic [31:0] d;
		host_seq_model_inst.host_access(1'h0, a, v, d);
		chk({31'h0, v}, 32'h1);
		chk(d, e);
	endtask

	task automatic clr(input logic [12:0] m0, input logic [12:0] m1);
		@(posedge clk_i);
		c0 <= m0;
		c1 <= m1;
		@(posedge clk_i);
		c0 <= '0;
		c1 <= '0;
		#1;
	endtask

	task automatic sample(input logic [15:0] d, input logic [12:0] e);
		@(posedge clk_i);
		av <= 1'h1;
		ad <= d;
		@(posedge clk_i);
		av <= 1'h0;
		ad <= ~d;
		#1;
		banks(e, e);
	endtask

	task automatic test_reset();
		banks(13'h0000, 13'h0000);
		rd_chk(16'h3010, 32'h0);
		rd_chk(16'h3014, 32'h0);
		rd_chk(16'h209C, 32'h10);
		rd_chk(16'h3018, 32'h0);
		$display("test reset done");
	endtask

	task automatic test_events();
		int          pos [6] = '{0, 1, 2, 3, 7, 8};
		logic [12:0] e;
		e = '0;
		for (int i = 0; i < 6; i++) begin
			@(posedge clk_i);
			ev <= 6'h01 << i;
			@(posedge clk_i);
			ev <= 6'h00;
			#1;
			e[pos[i]] = 1'h1;
			banks(e, e);
		end
		clr(13'h0002, 13'h0000);
		banks(e & 13'h1FFD, e);
		clr('1, '1);
		banks(13'h0000, 13'h0000);
		$display("test events done");
	endtask

	task automatic test_adc();
		sample(16'h0096, 13'h0000);
		sample(16'h00C8, 13'h0000);
		sample(16'h00C9, 13'h0020);
		sample(16'h0097, 13'h0020);
		sample(16'h0064, 13'h0060);
		sample(16'h0063, 13'h0070);
		rd_chk(16'h3014, 32'h70);
		clr('1, '1);
		$display("test adc done");
	endtask

	task automatic test_custom();
		logic        v;
		logic [31:0] d;
		host_seq_model_inst.host_access(1'h1, 16'h209C, v, d);
		banks(13'h0000, 13'h0000);
		rd_chk(16'h209C, 32'h10);
		host_seq_model_inst.seq_write(16'h2098, 32'hF);
		#1;
		banks(13'h0000, 13'h0000);
		host_seq_model_inst.seq_write(16'h209C, 32'h0);
		#1;
		banks(13'h0000, 13'h0000);
		host_seq_model_inst.seq_write(16'h209C, 32'h5);
		#1;
		banks(13'h0A00, 13'h0A00);
		host_seq_model_inst.seq_write(16'h209C, 32'hA);
		#1;
		banks(13'h1E00, 13'h1E00);
		$display("test custom done");
	endtask

	// Event and clear on one bit in one cycle; a raised lower limit
	// turns a sample that passed before into a fail
	task automatic test_set_wins();
		@(posedge clk_i);
		lo <= 16'h0100;
		av <= 1'h1;
		ad <= 16'h0080;
		c0 <= 13'h0210;
		c1 <= 13'h0000;
		@(posedge clk_i);
		av <= 1'h0;
		ad <= 16'hFF7F;
		c0 <= '0;
		#1;
		banks(13'h1C10, 13'h1E10);
		$display("test set wins done");
	endtask

	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		clk_i = 1'h0;
		forever #10 clk_i = ~clk_i;
	end

	initial begin
		#40000;
		mismatches++;
		summarize();
	end

	initial begin
		rst_n_i = 1'h0;
		ev = 6'h00;
		av = 1'h0;
		ad = 16'h0000;
		lo = 16'h0064;
		hi = 16'h00C8;
		stp = 16'h0032;
		c0 = '0;
		c1 = '0;
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'h1;
		test_reset();
		test_events();
		test_adc();
		test_custom();
		test_set_wins();
		summarize();
	end
endmodule
